// file: src/ulas_map.svh
// Constants of the U-loop activation sequencer: command codes, register fields, timer figures.
// Assumes a single 250 MHz clock; included by the sequencer files.
`ifndef ULAS_MAP_SVH
`define ULAS_MAP_SVH

// ********************
// Command and indication codes
// ********************
`define ULAS_CODE_PUP      4'h0
`define ULAS_CODE_RES      4'h1
`define ULAS_CODE_ERR      4'h4
`define ULAS_CODE_PDN      4'h5
`define ULAS_CODE_SYNC     4'h6
`define ULAS_CODE_ACTREQ   4'h8
`define ULAS_CODE_ACTDONE  4'hC
`define ULAS_CODE_DEACT    4'hF

// ********************
// Register layout
// ********************
`define ULAS_CMD_RESET     8'h0F
`define ULAS_FIELD_MSB     3
`define ULAS_REG_W         8

// ********************
// Timing
// ********************
`define ULAS_CLK_MHZ       250
`define ULAS_T_DEFAULT_MS  15000
`define ULAS_T_RESYNC_MS   480
`define ULAS_T_LOSS_MS     40
`define ULAS_CYC_PER_MS    (`ULAS_CLK_MHZ * 1000)
`define ULAS_DEA_FRAMES    4
`define ULAS_VALIDATE_N    3
`define ULAS_TONE_N        2

`endif

// file: src/ulas_pkg.sv
// Types of the U-loop activation sequencer.
// Assumes ulas_map.svh for constant values.
package ulas_pkg;
  typedef logic [3:0] ulas_code_t;

  typedef enum logic [9:0] {
    ULAS_OFF      = 10'b0000000001,
    ULAS_IDLE     = 10'b0000000010,
    ULAS_TRAIN    = 10'b0000000100,
    ULAS_PEND     = 10'b0000001000,
    ULAS_HOLD     = 10'b0000010000,
    ULAS_ACTIVE   = 10'b0000100000,
    ULAS_RESYNC   = 10'b0001000000,
    ULAS_DEASEND  = 10'b0010000000,
    ULAS_DEAWAIT  = 10'b0100000000,
    ULAS_FAIL     = 10'b1000000000
  } ulas_state_e;
endpackage

// file: src/ulas_if.sv
// Carrier between the sequencer and its timer unit.
// Assumes one clock domain.
interface ulas_timer_if;
  logic start15;
  logic start480;
  logic start40;
  logic stop;
  logic exp15;
  logic exp480;
  logic exp40;
  modport seq (output start15, start480, start40, stop, input exp15, exp480, exp40);
  modport tmr (input start15, start480, start40, stop, output exp15, exp480, exp40);
endinterface

// file: src/ulas_timers.sv
// Millisecond divider and the 15 s, 480 ms and 40 ms sequencer timers.
// Assumes one clock; expiry flags are single-cycle pulses.
`include "ulas_map.svh"
module ulas_timers #(
  parameter int CYC_PER_MS = `ULAS_CYC_PER_MS,
  parameter int T_DEF_MS   = `ULAS_T_DEFAULT_MS,
  parameter int T_RSY_MS   = `ULAS_T_RESYNC_MS,
  parameter int T_LOS_MS   = `ULAS_T_LOSS_MS
) (
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  // Control
  input  wire logic  defTimerEn,
  ulas_timer_if.tmr  tm
);
  initial begin
    if (CYC_PER_MS < 1 || T_DEF_MS < 1 || T_RSY_MS < 1 || T_LOS_MS < 1 || T_DEF_MS > 65535)
      $error("ulas_timers: bad timer parameters");
  end

  logic [31:0] preCnt;
  logic        msTick;
  logic [15:0] cnt15;
  logic [15:0] cnt480;
  logic [15:0] cnt40;
  logic        run15;
  logic        run480;
  logic        run40;

  assign msTick = (preCnt == 32'(CYC_PER_MS - 1));

  // ********************
  // Millisecond enable
  // ********************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt <= 32'h0000_0000;
    end else begin
      preCnt <= msTick ? 32'h0000_0000 : preCnt + 32'h0000_0001;
    end
  end

  // ********************
  // Timers
  // ********************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {run15, run480, run40} <= 3'h0;
      cnt15  <= 16'h0000;
      cnt480 <= 16'h0000;
      cnt40  <= 16'h0000;
      tm.exp15  <= 1'b0;
      tm.exp480 <= 1'b0;
      tm.exp40  <= 1'b0;
    end else begin
      tm.exp15  <= run15 && msTick && cnt15 == 16'(T_DEF_MS - 1) && defTimerEn;
      tm.exp480 <= run480 && msTick && cnt480 == 16'(T_RSY_MS - 1);
      tm.exp40  <= run40 && msTick && cnt40 == 16'(T_LOS_MS - 1);
      if (tm.stop) begin
        {run15, run480, run40} <= 3'h0;
      end else begin
        if (tm.start15) begin
          run15 <= 1'b1;
          cnt15 <= 16'h0000;
        end else if (run15 && msTick) begin
          cnt15 <= cnt15 + 16'h0001;
        end
        if (tm.start480) begin
          run480 <= 1'b1;
          cnt480 <= 16'h0000;
        end else if (run480 && msTick) begin
          cnt480 <= cnt480 + 16'h0001;
        end
        if (tm.start40) begin
          run40 <= 1'b1;
          cnt40 <= 16'h0000;
        end else if (run40 && msTick) begin
          cnt40 <= cnt40 + 16'h0001;
        end
      end
    end
  end
endmodule

// file: src/ulas_sequencer.sv
// Activation and deactivation sequencer of a 2B1Q U-loop transceiver, LT and NT roles.
// Assumes line events arrive as same-clock pulses/levels from the framer; wake tone is a pin.
`include "ulas_map.svh"
module ulas_sequencer
  import ulas_pkg::*;
#(
  parameter int CYC_PER_MS = `ULAS_CYC_PER_MS,
  parameter int T_DEF_MS   = `ULAS_T_DEFAULT_MS
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // Configuration
  input  wire logic                    ntMode,
  input  wire logic                    gciMode,
  input  wire logic                    breakpoint_two_enable,
  input  wire logic                    defTimerEn,
  // Command register port
  input  wire logic                    cmdWrite,
  input  wire logic [7:0]              cmdData,
  output logic      [7:0]              cmdReg,
  output logic      [7:0]              activation_indication,
  // Interrupt stack entry
  output logic                         intPush,
  output ulas_pkg::ulas_code_t         intCode,
  // GCI C/I channel
  output ulas_pkg::ulas_code_t         ciCmd,
  output ulas_pkg::ulas_code_t         ciInd,
  // Framer events
  input  wire logic                    superframeTick,
  input  wire logic                    sfSync,
  input  wire logic                    rxSignal,
  input  wire logic                    rxAct,
  input  wire logic                    rxDea,
  input  wire logic                    wakeTonePin,
  // Line control
  output logic                         powerOn,
  output logic                         oscEnable,
  output logic                         txEnable,
  output logic                         txAct,
  output logic                         txDea,
  output logic                         channelsOpen,
  output logic                         coldStart,
  output logic                         dspClear,
  output logic                         line_signal_detect_out_n
);
  ulas_state_e      state;
  ulas_state_e      next_state;
  ulas_timer_if     tif ();
  logic [1:0]       toneSync;
  logic             tone;
  logic             warmOk;
  logic [2:0]       valCnt;
  logic [2:0]       deaCnt;
  logic             actForce0;
  logic             seiForce;
  logic             rxActD;
  logic [3:0]       next_ind;
  logic [3:0]       code;
  logic             known;
  logic             sfOk;
  logic             actFall;

  initial begin
    if (CYC_PER_MS < 1) $error("ulas_sequencer: bad clock rate");
  end

  function automatic logic codeKnown(input logic [3:0] c);
    codeKnown = c == `ULAS_CODE_PUP || c == `ULAS_CODE_RES || c == `ULAS_CODE_ERR || c == `ULAS_CODE_PDN ||
                c == `ULAS_CODE_ACTREQ || c == `ULAS_CODE_ACTDONE || c == `ULAS_CODE_DEACT;
  endfunction

  ulas_timers #(
    .CYC_PER_MS (CYC_PER_MS),
    .T_DEF_MS   (T_DEF_MS),
    .T_RSY_MS   (`ULAS_T_RESYNC_MS),
    .T_LOS_MS   (`ULAS_T_LOSS_MS)
  ) u_timers (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .defTimerEn (defTimerEn),
    .tm         (tif.tmr)
  );

  // ********************
  // Decoding
  // ********************
  assign tone    = toneSync[1];
  assign code    = cmdData[`ULAS_FIELD_MSB:0];
  assign known   = cmdWrite && codeKnown(code) && cmdData[7:4] == 4'h0;
  assign sfOk    = sfSync && superframeTick;
  assign actFall = rxActD && !rxAct && superframeTick;

  // ********************
  // Wake tone synchroniser
  // ********************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      toneSync <= 2'h0;
    end else begin
      toneSync <= {toneSync[0], wakeTonePin};
    end
  end

  // ********************
  // Next state
  // ********************
  always_comb begin
    next_state = state;
    next_ind   = activation_indication[3:0];
    case (state)
      ULAS_OFF: begin
        if (tone) next_ind = ntMode ? `ULAS_CODE_PUP : `ULAS_CODE_ACTREQ;
        if (known && code == `ULAS_CODE_PUP) begin
          next_state = ULAS_IDLE;
          if (gciMode) next_ind = `ULAS_CODE_PUP;
        end
      end
      ULAS_IDLE: begin
        if (tone && !rxSignal) next_ind = ntMode ? `ULAS_CODE_PUP : `ULAS_CODE_ACTREQ;
        if (known && code == `ULAS_CODE_ACTREQ) next_state = ULAS_TRAIN;
      end
      ULAS_TRAIN: begin
        if (sfOk) begin
          if (ntMode) begin
            next_state = ULAS_PEND;
            next_ind = `ULAS_CODE_ACTREQ;
          end else if (breakpoint_two_enable) begin
            next_state = ULAS_HOLD;
            next_ind = `ULAS_CODE_SYNC;
          end else begin
            next_state = ULAS_ACTIVE;
            next_ind = `ULAS_CODE_ACTDONE;
          end
        end
      end
      ULAS_PEND: begin
        if (valCnt == 3'(`ULAS_VALIDATE_N)) begin
          next_state = ULAS_ACTIVE;
          next_ind = `ULAS_CODE_ACTDONE;
        end
      end
      ULAS_HOLD: begin
        if (known && code == `ULAS_CODE_ACTDONE) begin
          next_state = ULAS_ACTIVE;
          next_ind = `ULAS_CODE_ACTDONE;
        end
      end
      ULAS_ACTIVE: begin
        if (!sfSync) begin
          next_state = ULAS_RESYNC;
          next_ind = `ULAS_CODE_ERR;
        end else if (actFall) begin
          next_ind = `ULAS_CODE_ERR;
        end else if (ntMode && deaCnt == 3'(`ULAS_VALIDATE_N)) begin
          next_state = ULAS_DEAWAIT;
          next_ind = `ULAS_CODE_PUP;
        end else if (!ntMode && known && code == `ULAS_CODE_PUP) begin
          next_state = ULAS_DEASEND;
        end
      end
      ULAS_RESYNC: begin
        if (sfSync) begin
          next_state = ULAS_ACTIVE;
          next_ind = `ULAS_CODE_ACTDONE;
        end else if (tif.exp480 || !rxSignal) begin
          next_state = ULAS_IDLE;
          next_ind = `ULAS_CODE_DEACT;
        end
      end
      ULAS_DEASEND: begin
        if (deaCnt == 3'(`ULAS_DEA_FRAMES)) next_state = ULAS_DEAWAIT;
      end
      ULAS_DEAWAIT: begin
        if (!rxSignal || tif.exp40) begin
          next_state = ULAS_IDLE;
          next_ind = `ULAS_CODE_DEACT;
        end
      end
      ULAS_FAIL: begin
        next_state = ULAS_IDLE;
        next_ind = `ULAS_CODE_DEACT;
      end
      default: begin
        next_state = ULAS_OFF;
      end
    endcase
    if (tif.exp15 && (state == ULAS_TRAIN || state == ULAS_PEND || state == ULAS_HOLD)) begin
      next_state = ULAS_FAIL;
      next_ind = `ULAS_CODE_ERR;
    end
    if (known && code == `ULAS_CODE_RES && state != ULAS_OFF) begin
      next_state = ULAS_IDLE;
    end
    if (known && (code == `ULAS_CODE_PDN ||
        (code == `ULAS_CODE_DEACT && activation_indication[3:0] == `ULAS_CODE_DEACT))) begin
      next_state = ULAS_OFF;
    end
  end

  // ********************
  // State and indications
  // ********************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ULAS_OFF;
      activation_indication <= `ULAS_CMD_RESET;
      intPush <= 1'b0;
      intCode <= `ULAS_CODE_DEACT;
    end else begin
      state <= next_state;
      activation_indication <= {4'h0, next_ind};
      intPush <= !gciMode && next_ind != activation_indication[3:0];
      intCode <= next_ind;
    end
  end

  // ********************
  // Command register
  // ********************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdReg <= `ULAS_CMD_RESET;
    end else if (next_state == ULAS_IDLE && (state == ULAS_FAIL || next_ind == `ULAS_CODE_DEACT) &&
                 state != ULAS_IDLE && !(known && code == `ULAS_CODE_RES)) begin
      cmdReg <= `ULAS_CMD_RESET;
    end else if (known) begin
      cmdReg <= {4'h0, code};
    end
  end

  // ********************
  // Overhead bits and counters
  // ********************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      valCnt <= 3'h0;
      deaCnt <= 3'h0;
      rxActD <= 1'b0;
      actForce0 <= 1'b0;
      seiForce <= 1'b0;
      warmOk <= 1'b0;
      coldStart <= 1'b1;
      dspClear <= 1'b0;
    end else begin
      dspClear <= known && code == `ULAS_CODE_RES;
      if (superframeTick) rxActD <= rxAct;
      if (state != next_state) begin
        valCnt <= 3'h0;
        deaCnt <= 3'h0;
      end else if (superframeTick) begin
        if (state == ULAS_PEND && rxAct && txAct) valCnt <= valCnt + 3'h1;
        if ((state == ULAS_DEASEND) || (state == ULAS_ACTIVE && ntMode && !rxDea)) begin
          deaCnt <= deaCnt + 3'h1;
        end else if (state == ULAS_ACTIVE) begin
          deaCnt <= 3'h0;
        end
      end
      if (known && code == `ULAS_CODE_ERR && state == ULAS_ACTIVE && !ntMode) actForce0 <= 1'b1;
      if (known && code == `ULAS_CODE_ERR && ntMode) seiForce <= 1'b1;
      if ((known && code == `ULAS_CODE_ACTDONE) || next_state == ULAS_IDLE || next_state == ULAS_OFF) begin
        actForce0 <= 1'b0;
        seiForce <= 1'b0;
      end
      if (state == ULAS_DEAWAIT && next_state == ULAS_IDLE) warmOk <= 1'b1;
      if (state == ULAS_FAIL || (known && code == `ULAS_CODE_RES)) warmOk <= 1'b0;
      if (state == ULAS_IDLE && next_state == ULAS_TRAIN) coldStart <= !warmOk;
      if (known && code == `ULAS_CODE_RES) coldStart <= 1'b1;
    end
  end

  // ********************
  // Line outputs
  // ********************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerOn <= 1'b0;
      oscEnable <= 1'b0;
      txEnable <= 1'b0;
      txAct <= 1'b0;
      txDea <= 1'b1;
      channelsOpen <= 1'b0;
      line_signal_detect_out_n <= 1'b1;
      ciCmd <= `ULAS_CODE_DEACT;
      ciInd <= `ULAS_CODE_DEACT;
    end else begin
      powerOn <= next_state != ULAS_OFF;
      oscEnable <= next_state != ULAS_OFF;
      txEnable <= next_state inside {ULAS_TRAIN, ULAS_PEND, ULAS_HOLD, ULAS_ACTIVE, ULAS_RESYNC, ULAS_DEASEND};
      txDea <= next_state != ULAS_DEASEND;
      if (next_state == ULAS_ACTIVE && !actForce0 && !seiForce && !(known && code == `ULAS_CODE_ERR)) begin
        txAct <= 1'b1;
      end else if (next_state == ULAS_PEND && ((known && code == `ULAS_CODE_ACTDONE) || txAct) && !seiForce) begin
        txAct <= 1'b1;
      end else begin
        txAct <= 1'b0;
      end
      channelsOpen <= next_state == ULAS_ACTIVE && !actForce0;
      line_signal_detect_out_n <= !(next_state == ULAS_OFF && tone);
      ciCmd <= gciMode ? cmdReg[3:0] : `ULAS_CODE_DEACT;
      ciInd <= gciMode ? next_ind : `ULAS_CODE_DEACT;
    end
  end

  // ********************
  // Timer control
  // ********************
  assign tif.start15  = state == ULAS_IDLE && next_state == ULAS_TRAIN;
  assign tif.start480 = state == ULAS_ACTIVE && next_state == ULAS_RESYNC;
  assign tif.start40  = state != ULAS_DEAWAIT && next_state == ULAS_DEAWAIT;
  assign tif.stop     = next_state == ULAS_OFF || next_state == ULAS_IDLE;
endmodule

// file: tb/ulas_far_end.sv
// Far-end transceiver on the loop: superframe timing, lock and overhead bits.
// Assumes the bench drives linkUp, farAct, farDea and tone just after a clock edge.
module ulas_far_end #(
  parameter int SF_CYC  = 8,
  parameter int LOCK_SF = 2
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Near-end line state
  input  wire logic txEnable,
  input  wire logic txDea,
  // Bench control
  input  wire logic linkUp,
  input  wire logic farAct,
  input  wire logic farDea,
  input  wire logic tone,
  // Framer events to the near end
  output logic      superframeTick,
  output logic      sfSync,
  output logic      rxSignal,
  output logic      rxAct,
  output logic      rxDea,
  output logic      wakeTonePin
);
  // ********************
  // Line model
  // ********************
  logic [7:0] sfCnt;
  logic [3:0] syncCnt;
  logic [2:0] deaSeen;
  logic       wander;
  assign rxSignal       = linkUp && deaSeen != 3'h4;
  assign superframeTick = rxSignal && sfCnt == 8'(SF_CYC - 1);
  assign sfSync         = syncCnt >= 4'(LOCK_SF);
  // Bits wander unless locked, so a stale value never passes for data
  assign rxAct          = sfSync ? farAct : wander;
  assign rxDea          = sfSync ? farDea : ~wander;
  assign wakeTonePin    = tone && !txEnable;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfCnt <= 8'h00;
      syncCnt <= 4'h0;
      deaSeen <= 3'h0;
      wander <= 1'b0;
    end else begin
      wander <= ~wander;
      sfCnt <= superframeTick ? 8'h00 : sfCnt + 8'(rxSignal);
      syncCnt <= (!rxSignal || !txEnable) ? 4'h0 : syncCnt + 4'(superframeTick && !sfSync);
      deaSeen <= !linkUp ? 3'h0 : deaSeen + 3'(superframeTick && !txDea && txEnable);
    end
  end
endmodule

// file: tb/ulas_sequencer_sva.sv
// Port checker of the activation sequencer.
// Assumes it is bound to ulas_sequencer.
module ulas_sequencer_sva #(
  parameter int CYC_PER_MS = 4,
  parameter int T_DEF_MS   = 60
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Watched ports
  input wire logic       gciMode,
  input wire logic       cmdWrite,
  input wire logic [7:0] cmdData,
  input wire logic [7:0] cmdReg,
  input wire logic [7:0] activation_indication,
  input wire logic       intPush,
  input wire logic [3:0] intCode,
  input wire logic [3:0] ciCmd,
  input wire logic [3:0] ciInd,
  input wire logic       powerOn,
  input wire logic       oscEnable,
  input wire logic       txAct,
  input wire logic       channelsOpen,
  input wire logic       coldStart,
  input wire logic       dspClear,
  input wire logic       line_signal_detect_out_n,
  input wire logic       wakeTonePin
);
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire       rsvd = cmdData[7:4] != 4'h0 || !(cmdData[3:0] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'hC, 4'hF});
  wire [3:0] ind  = activation_indication[3:0];
  chk_rsvd_no_change: assert property (
    cmdWrite && rsvd |=> $stable(cmdReg) && $stable(activation_indication)) else $error("reserved code acted");
  chk_pup_wakes: assert property (
    cmdWrite && cmdData == 8'h00 && !powerOn |=> powerOn && oscEnable) else $error("power-up missed");
  chk_pdn_at_once: assert property (
    cmdWrite && cmdData == 8'h05 |=> !powerOn) else $error("power-down late");
  chk_res_clears: assert property (
    cmdWrite && cmdData == 8'h01 && powerOn |=> dspClear && coldStart) else $error("reset no clear");
  chk_ci_mirror: assert property (
    gciMode && $past(gciMode) && $stable(cmdReg) && $stable(activation_indication)
    |-> ciCmd == cmdReg[3:0] && ciInd == ind) else $error("C/I copy wrong");
  chk_push_on_change: assert property (
    !gciMode && $changed(activation_indication) |-> intPush && intCode == ind) else $error("push missing");
  chk_push_gci_quiet: assert property (
    gciMode |-> !intPush) else $error("push in GCI mode");
  chk_open_needs_ai: assert property (
    $rose(channelsOpen) |-> ind == 4'hC) else $error("channels opened early");
  chk_act_forced_low: assert property (
    cmdWrite && cmdData == 8'h04 && ind == 4'hC |=> !txAct) else $error("act not forced");
  chk_lsd_only_off: assert property (
    !line_signal_detect_out_n |-> !powerOn) else $error("detect pin low while on");
  chk_lsd_on_tone: assert property (
    wakeTonePin && !powerOn && ind == 4'hF |-> ##[1:8] !line_signal_detect_out_n) else $error("tone missed");
endmodule
bind ulas_sequencer ulas_sequencer_sva #(.CYC_PER_MS(CYC_PER_MS), .T_DEF_MS(T_DEF_MS)) u_sva (
  .ref_clk, .rst_n, .gciMode, .cmdWrite, .cmdData, .cmdReg, .activation_indication, .intPush, .intCode,
  .ciCmd, .ciInd, .powerOn, .oscEnable, .txAct, .channelsOpen, .coldStart, .dspClear,
  .line_signal_detect_out_n, .wakeTonePin);

// file: tb/tb_u_loop_activation_sequencer.sv
// Self-checking bench of the activation sequencer in LT and NT roles.
// Assumes the far-end model and the bound checker.
module tb_u_loop_activation_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Signals and models
  // ********************
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ntMode, gciMode, breakpoint_two_enable, defTimerEn, cmdWrite;
  logic [7:0] cmdData, cmdReg, activation_indication;
  logic [3:0] intCode, ciCmd, ciInd;
  logic       intPush, superframeTick, sfSync, rxSignal, rxAct, rxDea, wakeTonePin;
  logic       powerOn, oscEnable, txEnable, txAct, txDea, channelsOpen, coldStart, dspClear;
  logic       line_signal_detect_out_n, linkUp, farAct, farDea, tone;
  int         fails = 0;
  int         comparisons = 0;
  int         deaCnt = 0;
  always #2 ref_clk = ~ref_clk;
  ulas_sequencer #(.CYC_PER_MS(4), .T_DEF_MS(60)) dut (
    .ref_clk, .rst_n, .ntMode, .gciMode, .breakpoint_two_enable, .defTimerEn, .cmdWrite, .cmdData,
    .cmdReg, .activation_indication, .intPush, .intCode, .ciCmd, .ciInd, .superframeTick, .sfSync,
    .rxSignal, .rxAct, .rxDea, .wakeTonePin, .powerOn, .oscEnable, .txEnable, .txAct, .txDea,
    .channelsOpen, .coldStart, .dspClear, .line_signal_detect_out_n);
  ulas_far_end far (
    .ref_clk, .rst_n, .txEnable, .txDea, .linkUp, .farAct, .farDea, .tone,
    .superframeTick, .sfSync, .rxSignal, .rxAct, .rxDea, .wakeTonePin);
  always @(posedge ref_clk) begin
    if (superframeTick && !txDea && txEnable) begin
      deaCnt++;
    end
  end
  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    #1 cmdWrite = 1'b1;
    cmdData = d;
    step(1);
    cmdWrite = 1'b0;
    step(1);
  endtask
  task automatic waitInd(input logic [3:0] code, input int lim);
    int n;
    n = 0;
    while (activation_indication[3:0] !== code && n < lim) begin
      step(1);
      n++;
    end
    chk(activation_indication, {4'h0, code});
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  // ********************
  // Tests
  // ********************
  initial begin
    {ntMode, gciMode, breakpoint_two_enable, cmdWrite, linkUp, farAct, farDea, tone} = '0;
    defTimerEn = 1'b1;
    cmdData = 8'h00;
    step(4);
    rst_n = 1'b1;
    chk(cmdReg, 8'h0F);
    chk({4'h0, txDea, coldStart, line_signal_detect_out_n, powerOn}, 8'h0E);
    chk({ciCmd, ciInd}, 8'hFF);
    wr(8'h02);
    wr(8'h18);
    chk(cmdReg, 8'h0F);
    waitInd(4'hF, 1);
    tone = 1'b1;
    waitInd(4'h8, 20);
    chk({7'h0, line_signal_detect_out_n}, 8'h00);
    tone = 1'b0;
    wr(8'h00);
    chk({6'h0, powerOn, oscEnable}, 8'h03);
    {linkUp, farAct, farDea} = 3'b111;
    wr(8'h08);
    chk({6'h0, txEnable, coldStart}, 8'h03);
    waitInd(4'hC, 200);
    chk({6'h0, txAct, channelsOpen}, 8'h03);
    wr(8'h04);
    chk({7'h0, txAct}, 8'h00);
    deaCnt = 0;
    wr(8'h00);
    waitInd(4'hF, 400);
    chk(8'(deaCnt), 8'h04);
    chk({cmdReg[3:0], 3'h0, txEnable}, 8'hF0);
    linkUp = 1'b0;
    wr(8'h0F);
    chk({7'h0, powerOn}, 8'h00);
    wr(8'h00);
    linkUp = 1'b1;
    breakpoint_two_enable = 1'b1;
    wr(8'h08);
    chk({7'h0, coldStart}, 8'h00);
    for (int n = 0; n < 200 && !sfSync; n++) begin
      step(1);
    end
    step(8);
    chk({6'h0, txAct, channelsOpen}, 8'h00);
    wr(8'h0C);
    chk({7'h0, txAct}, 8'h01);
    waitInd(4'hC, 50);
    farAct = 1'b0;
    waitInd(4'h4, 40);
    linkUp = 1'b0;
    waitInd(4'hF, 2000);
    {breakpoint_two_enable, farAct} = 2'b01;
    wr(8'h00);
    wr(8'h08);
    waitInd(4'h4, 300);
    waitInd(4'hF, 5);
    chk(cmdReg, 8'h0F);
    defTimerEn = 1'b0;
    wr(8'h08);
    step(300);
    chk({7'h0, activation_indication[3:0] == 4'h4}, 8'h00);
    wr(8'h01);
    chk({7'h0, coldStart}, 8'h01);
    defTimerEn = 1'b1;
    wr(8'h05);
    chk({7'h0, powerOn}, 8'h00);
    gciMode = 1'b1;
    wr(8'h00);
    chk({4'h0, ciCmd}, 8'h00);
    gciMode = 1'b0;
    {ntMode, linkUp, farAct} = 3'b110;
    wr(8'h08);
    waitInd(4'h8, 200);
    chk({7'h0, txAct}, 8'h00);
    wr(8'h0C);
    chk({7'h0, txAct}, 8'h01);
    farAct = 1'b1;
    waitInd(4'hC, 60);
    wr(8'h04);
    chk({7'h0, txAct}, 8'h00);
    farDea = 1'b0;
    waitInd(4'h0, 60);
    linkUp = 1'b0;
    waitInd(4'hF, 400);
    wrap_up();
  end
endmodule
